/* File: rtl/ocf_cfg.svh */
// constants for the output state and fault latch controller
// assumes inclusion by bare name from the sequencer, the controller and the bench
`ifndef OCF_CFG_SVH
`define OCF_CFG_SVH
// register byte addresses
`define OCF_A_ENABLE 8'h00
`define OCF_A_COUPLE 8'h04
`define OCF_A_RELAY 8'h08
`define OCF_A_COMP 8'h0C
`define OCF_A_DFI 8'h10
`define OCF_A_PON 8'h14
`define OCF_A_PROT 8'h18
`define OCF_A_STATUS 8'h1C
// enable write fields
`define OCF_B_EN_STATE 0
`define OCF_F_EN_CHAN 2:1
`define OCF_CH_NONE 2'h0
`define OCF_CH_MAIN 2'h1
`define OCF_CH_SECOND 2'h2
// compensation write fields
`define OCF_F_COMP 1:0
`define OCF_B_COMP_LEGACY 4
`define OCF_B_COMP_HIGH 0
// indicator fields
`define OCF_B_DFI_EN 0
`define OCF_F_DFI_SRC 3:1
// protection fields
`define OCF_B_PROT_CLEAR 0
`define OCF_B_PROT_OCP 1
`define OCF_F_PROT_RI 3:2
// relay fields
`define OCF_F_RELAY1 1:0
`define OCF_F_RELAY2 3:2
`define OCF_B_ON_HOT 1
// relay codes: upper bit on-transition hot, lower bit off-transition hot
`define OCF_RELAY_DD 2'h0
`define OCF_RELAY_DH 2'h1
`define OCF_RELAY_HD 2'h2
`define OCF_RELAY_HH 2'h3
// compensation codes
`define OCF_COMP_SLOW_LOCAL 2'h0
`define OCF_COMP_SLOW_REMOTE 2'h1
`define OCF_COMP_FAST_LOCAL 2'h2
`define OCF_COMP_FAST_REMOTE 2'h3
// indicator source codes
`define OCF_SRC_OFF 3'h0
`define OCF_SRC_QUES 3'h1
`define OCF_SRC_OPER 3'h2
`define OCF_SRC_ESB 3'h3
`define OCF_SRC_RQS 3'h4
// status byte bit positions
`define OCF_SB_QUES 3
`define OCF_SB_ESB 5
`define OCF_SB_RQS 6
`define OCF_SB_OPER 7
// remote inhibit modes
`define OCF_RI_OFF 2'h0
`define OCF_RI_LIVE 2'h1
`define OCF_RI_LATCH 2'h2
// reset values
`define OCF_RST_COUPLE 1'h1
`define OCF_RST_BYTE 8'h00
`endif

/* File: rtl/ocf_pkg.sv */
// types shared by the output controller and its channel sequencer
// assumes ocf_cfg.svh is on the include path
package ocf_pkg;
	typedef logic [1:0] ocf_relay_t;
	typedef logic [1:0] ocf_comp_t;
	typedef logic [2:0] ocf_src_t;
	typedef logic [7:0] ocf_byte_t;
	typedef enum logic [1:0] {
		OCF_ST_OFF,
		OCF_ST_RISE,
		OCF_ST_ON,
		OCF_ST_FALL
	} ocf_chan_st_t;
endpackage

/* File: rtl/ocf_chan.sv */
// per-output relay and level sequencer
// assumes en comes from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "ocf_cfg.svh"
module ocf_chan (
	input wire logic clk, // system clock
	input wire logic rst, // async reset, active high
	input wire logic en, // effective output enable
	input wire ocf_pkg::ocf_relay_t mode_pend, // pending relay mode
	output ocf_pkg::ocf_relay_t mode_act, // relay mode in force
	output logic level_on, // output level programmed
	output logic relay_closed, // sense relays closed
	output logic sense_check // open-sense check pulse
);
	import ocf_pkg::*;
	ocf_chan_st_t st_q;
	ocf_relay_t mode_q;
	logic level_q, relay_q, check_q;
	logic on_hot;
	assign on_hot = mode_q[`OCF_B_ON_HOT];
	assign mode_act = mode_q;
	assign level_on = level_q;
	assign relay_closed = relay_q;
	assign sense_check = check_q;
	// pending mode is taken only while idle and disabled
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode_q <= `OCF_RELAY_HH;
		end else if (st_q == OCF_ST_OFF && !en) begin
			mode_q <= mode_pend;
		end
	end
	// transition sequence
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= OCF_ST_OFF;
			level_q <= 1'b0;
			relay_q <= 1'b0;
			check_q <= 1'b0;
		end else begin
			check_q <= 1'b0;
			case (st_q)
				OCF_ST_OFF: begin
					if (en) begin
						st_q <= OCF_ST_RISE;
						if (on_hot) begin
							level_q <= 1'b1;
						end else begin
							relay_q <= 1'b1;
							check_q <= 1'b1;
						end
					end
				end
				OCF_ST_RISE: begin
					st_q <= OCF_ST_ON;
					level_q <= 1'b1;
					relay_q <= 1'b1;
				end
				OCF_ST_ON: begin
					if (!en) begin
						st_q <= OCF_ST_FALL;
						if (mode_q[0]) begin
							relay_q <= 1'b0;
						end else begin
							level_q <= 1'b0;
						end
					end
				end
				OCF_ST_FALL: begin
					st_q <= OCF_ST_OFF;
					level_q <= 1'b0;
					relay_q <= 1'b0;
				end
				default: begin
					st_q <= OCF_ST_OFF;
				end
			endcase
		end
	end
	// checks of the sequence
	property p_check_dry;
		@(posedge clk) disable iff (rst) check_q |-> !on_hot && relay_q && !level_q;
	endproperty
	a_check_dry: assert property (p_check_dry) else $error("sense check on hot mode");
	property p_hot_order;
		@(posedge clk) disable iff (rst)
		($rose(relay_q) && on_hot) |-> (level_q && $past(level_q));
	endproperty
	a_hot_order: assert property (p_hot_order) else $error("relay closed before level");
	property p_mode_hold;
		@(posedge clk) disable iff (rst) (st_q != OCF_ST_OFF) |=> $stable(mode_q);
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("relay mode changed while on");
	c_hot_on: cover property (@(posedge clk) disable iff (rst) on_hot && $rose(relay_q));
endmodule
`default_nettype wire

/* File: rtl/ocf_ctrl.sv */
// output state, relay mode, compensation, indicator and fault latch control
// assumes a same-clock register master; fault and inhibit pins are asynchronous
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ocf_cfg.svh"
module ocf_ctrl (
	input wire logic clk, // 100 MHz clock
	input wire logic rst, // async reset, active high
	input wire ocf_pkg::ocf_byte_t addr, // register byte address
	input wire ocf_pkg::ocf_byte_t wdata, // write data
	input wire logic wr, // write strobe
	input wire logic rd, // read strobe
	output ocf_pkg::ocf_byte_t rdata, // read data, cycle after rd
	input wire ocf_pkg::ocf_byte_t status_byte, // status byte, same clock
	input wire logic ov_in, // overvoltage pin
	input wire logic ot_in, // overtemperature pin
	input wire logic [1:0] cc_in, // constant-current pins per output
	input wire logic remote_inhibit_in_n, // inhibit pin, low true
	input wire logic nv_ok, // nv contents valid at power-up
	input wire logic [3:0] nv_relay, // stored relay modes
	input wire logic nv_pon, // stored power-on choice
	output logic [1:0] level_on, // level programmed per output
	output logic [1:0] relay_closed, // sense relays per output
	output logic [1:0] sense_check, // open-sense check pulse
	output ocf_pkg::ocf_comp_t comp_mode, // compensation selector
	output logic fault_indicator_out, // fault indicator pin
	output logic recall_slot_zero, // power-on recalls slot zero
	output logic fault_latched, // protection latch state
	output logic ques_oc // questionable overcurrent bit
);
	import ocf_pkg::*;
	// synchronisers for the asynchronous pins
	logic [4:0] sync1_q, sync2_q;
	logic ov_s, ot_s, inh_s;
	logic [1:0] cc_s;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1_q <= 5'h00;
			sync2_q <= 5'h00;
		end else begin
			sync1_q <= {ov_in, ot_in, cc_in, ~remote_inhibit_in_n};
			sync2_q <= sync1_q;
		end
	end
	assign {ov_s, ot_s, cc_s, inh_s} = sync2_q;
	// register decode
	logic wr_en, wr_cpl, wr_rly, wr_cmp, wr_dfi, wr_pon, wr_prot;
	assign wr_en = wr && addr == `OCF_A_ENABLE;
	assign wr_cpl = wr && addr == `OCF_A_COUPLE;
	assign wr_rly = wr && addr == `OCF_A_RELAY;
	assign wr_cmp = wr && addr == `OCF_A_COMP;
	assign wr_dfi = wr && addr == `OCF_A_DFI;
	assign wr_pon = wr && addr == `OCF_A_PON;
	assign wr_prot = wr && addr == `OCF_A_PROT;
	// output coupling
	logic couple_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			couple_q <= `OCF_RST_COUPLE;
		end else if (wr_cpl) begin
			couple_q <= wdata[0];
		end
	end
	// enable write targets
	logic [1:0] ch;
	logic hit_main, hit_second;
	assign ch = wdata[`OCF_F_EN_CHAN];
	assign hit_main = couple_q || ch != `OCF_CH_SECOND;
	assign hit_second = couple_q || ch == `OCF_CH_SECOND;
	// stored enables survive a fault so a clear restores them
	logic [1:0] en_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			en_q <= 2'h0;
		end else if (wr_en) begin
			if (hit_main) begin
				en_q[0] <= wdata[`OCF_B_EN_STATE];
			end
			if (hit_second) begin
				en_q[1] <= wdata[`OCF_B_EN_STATE];
			end
		end
	end
	// relay modes, loaded from nv storage once after reset release when nv_ok is set
	ocf_relay_t pend_q [2];
	logic loaded_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			loaded_q <= 1'b0;
			pend_q[0] <= `OCF_RELAY_HH;
			pend_q[1] <= `OCF_RELAY_HH;
		end else if (!loaded_q) begin
			loaded_q <= 1'b1;
			if (nv_ok) begin
				pend_q[0] <= nv_relay[`OCF_F_RELAY1];
				pend_q[1] <= nv_relay[`OCF_F_RELAY2];
			end
		end else if (wr_rly) begin
			pend_q[0] <= wdata[`OCF_F_RELAY1];
			pend_q[1] <= wdata[`OCF_F_RELAY2];
		end
	end
	// power-on selection
	logic pon_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pon_q <= 1'b0;
		end else if (!loaded_q) begin
			pon_q <= nv_ok && nv_pon;
		end else if (wr_pon) begin
			pon_q <= wdata[0];
		end
	end
	assign recall_slot_zero = pon_q;
	// compensation selector with legacy mapping
	ocf_comp_t comp_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			comp_q <= `OCF_COMP_FAST_REMOTE;
		end else if (wr_cmp) begin
			if (wdata[`OCF_B_COMP_LEGACY]) begin
				comp_q <= wdata[`OCF_B_COMP_HIGH] ? `OCF_COMP_FAST_REMOTE
					: `OCF_COMP_SLOW_LOCAL;
			end else begin
				comp_q <= wdata[`OCF_F_COMP];
			end
		end
	end
	assign comp_mode = comp_q;
	// fault indicator settings
	logic dfi_en_q;
	ocf_src_t src_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dfi_en_q <= 1'b0;
			src_q <= `OCF_SRC_OFF;
		end else if (wr_dfi) begin
			dfi_en_q <= wdata[`OCF_B_DFI_EN];
			src_q <= wdata[`OCF_F_DFI_SRC];
		end
	end
	// indicator source select
	logic sel_bit;
	always_comb begin
		case (src_q)
			`OCF_SRC_QUES: sel_bit = status_byte[`OCF_SB_QUES];
			`OCF_SRC_OPER: sel_bit = status_byte[`OCF_SB_OPER];
			`OCF_SRC_ESB: sel_bit = status_byte[`OCF_SB_ESB];
			`OCF_SRC_RQS: sel_bit = status_byte[`OCF_SB_RQS];
			default: sel_bit = 1'b0;
		endcase
	end
	// indicator pin
	logic dfi_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dfi_q <= 1'b0;
		end else begin
			dfi_q <= dfi_en_q && sel_bit;
		end
	end
	assign fault_indicator_out = dfi_q;
	// protection settings
	logic ocp_en_q;
	logic [1:0] ri_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ocp_en_q <= 1'b0;
			ri_q <= `OCF_RI_OFF;
		end else if (wr_prot) begin
			ocp_en_q <= wdata[`OCF_B_PROT_OCP];
			ri_q <= wdata[`OCF_F_PROT_RI];
		end
	end
	// fault causes
	logic oc_c, inh_c, cause, clr;
	assign oc_c = ocp_en_q && (|cc_s);
	assign inh_c = ri_q == `OCF_RI_LATCH && inh_s;
	assign cause = ov_s || ot_s || oc_c || inh_c;
	assign clr = wr_prot && wdata[`OCF_B_PROT_CLEAR];
	// latch: a present cause always wins over a clear
	logic latch_q, oc_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			latch_q <= 1'b0;
		end else if (cause) begin
			latch_q <= 1'b1;
		end else if (clr) begin
			latch_q <= 1'b0;
		end
	end
	// questionable overcurrent bit
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			oc_q <= 1'b0;
		end else if (oc_c) begin
			oc_q <= 1'b1;
		end else if (clr) begin
			oc_q <= 1'b0;
		end
	end
	assign fault_latched = latch_q;
	assign ques_oc = oc_q;
	// effective enables: live inhibit masks without latching
	logic live_inh;
	logic [1:0] eff;
	assign live_inh = ri_q == `OCF_RI_LIVE && inh_s;
	assign eff = (latch_q || live_inh) ? 2'h0 : en_q;
	// per-output sequencers
	ocf_relay_t act [2];
	for (genvar i = 0; i < 2; i++) begin : g_chan
		ocf_chan u_chan (
			.clk(clk),
			.rst(rst),
			.en(eff[i]),
			.mode_pend(pend_q[i]),
			.mode_act(act[i]),
			.level_on(level_on[i]),
			.relay_closed(relay_closed[i]),
			.sense_check(sense_check[i])
		);
	end
	// read back mux
	ocf_byte_t rmux, rdata_q;
	always_comb begin
		case (addr)
			`OCF_A_ENABLE: rmux = {6'h00, en_q};
			`OCF_A_COUPLE: rmux = {7'h00, couple_q};
			`OCF_A_RELAY: rmux = {4'h0, pend_q[1], pend_q[0]};
			`OCF_A_COMP: rmux = {6'h00, comp_q};
			`OCF_A_DFI: rmux = {4'h0, src_q, dfi_en_q};
			`OCF_A_PON: rmux = {7'h00, pon_q};
			`OCF_A_PROT: rmux = {4'h0, ri_q, ocp_en_q, 1'b0};
			`OCF_A_STATUS: rmux = {act[1], act[0], oc_q, inh_s, cause, latch_q};
			default: rmux = `OCF_RST_BYTE;
		endcase
	end
	// read data stands for the one cycle after the strobe
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata_q <= `OCF_RST_BYTE;
		end else begin
			rdata_q <= rd ? rmux : `OCF_RST_BYTE;
		end
	end
	assign rdata = rdata_q;
	// checks
	property p_en_off;
		@(posedge clk) disable iff (rst)
		(wr_en && hit_main && !wdata[`OCF_B_EN_STATE]) |=> !en_q[0] ##[1:3] !level_on[0];
	endproperty
	a_en_off: assert property (p_en_off) else $error("main enable not cleared");
	property p_coupled;
		@(posedge clk) disable iff (rst) (wr_en && couple_q) |=> en_q[0] == en_q[1];
	endproperty
	a_coupled: assert property (p_coupled) else $error("coupled outputs differ");
	property p_uncoupled;
		@(posedge clk) disable iff (rst)
		(wr_en && !couple_q && ch == `OCF_CH_NONE) |=> $stable(en_q[1]);
	endproperty
	a_uncoupled: assert property (p_uncoupled) else $error("second output hit");
	property p_zero;
		@(posedge clk) disable iff (rst) $fell(eff[0]) |-> ##[1:3] !level_on[0];
	endproperty
	a_zero: assert property (p_zero) else $error("disabled output still driven");
	property p_hold;
		@(posedge clk) disable iff (rst) (cause && loaded_q) |=> latch_q && eff == 2'h0;
	endproperty
	a_hold: assert property (p_hold) else $error("latch released with cause");
	property p_restore;
		@(posedge clk) disable iff (rst) ($fell(latch_q) && !live_inh) |-> eff == en_q;
	endproperty
	a_restore: assert property (p_restore) else $error("enable not restored");
	property p_dfi;
		@(posedge clk) disable iff (rst)
		##1 (fault_indicator_out == $past(dfi_en_q && sel_bit && src_q != `OCF_SRC_OFF));
	endproperty
	a_dfi: assert property (p_dfi) else $error("indicator mismatch");
	property p_legacy;
		@(posedge clk) disable iff (rst)
		(wr_cmp && wdata[`OCF_B_COMP_LEGACY] && !wdata[`OCF_B_COMP_HIGH])
		|=> comp_mode == `OCF_COMP_SLOW_LOCAL;
	endproperty
	a_legacy: assert property (p_legacy) else $error("legacy low mismatch");
	property p_oc;
		@(posedge clk) disable iff (rst) oc_c |=> ques_oc && fault_latched;
	endproperty
	a_oc: assert property (p_oc) else $error("overcurrent not latched");
	c_trip_clear: cover property (@(posedge clk) disable iff (rst) latch_q ##[1:20] !latch_q);
	c_coupled_on: cover property (@(posedge clk) disable iff (rst) wr_en && couple_q);
	c_dfi: cover property (@(posedge clk) disable iff (rst) $rose(fault_indicator_out));
endmodule
`default_nettype wire

/* File: bench/ocf_plant.sv */
// far-side model: power stage pins and non-volatile store
// assumes the bench steers its fault requests on the same clock
`timescale 1ns/1ps
`default_nettype none
module ocf_plant #(
	parameter logic [3:0] NV_RELAY = 4'h9, // stored relay modes
	parameter logic NV_PON = 1'b1 // stored power-on choice
) (
	input wire logic [1:0] level_on, // levels from controller
	input wire logic overload, // load above current limit
	input wire logic [1:0] fault_req, // temperature, voltage
	input wire logic inh_req, // inhibit asserted
	input wire logic nv_valid, // store contents good
	output logic [1:0] cc_in, // current limit per output
	output logic ov_in, // overvoltage
	output logic ot_in, // overtemperature
	output logic remote_inhibit_in_n, // inhibit, low true
	output logic nv_ok, // store valid
	output logic [3:0] nv_relay, // relay modes
	output logic nv_pon // power-on choice
);
	// current limit only bites on a driven output
	assign cc_in = {2{overload}} & level_on;
	assign ov_in = fault_req[0];
	assign ot_in = fault_req[1];
	assign remote_inhibit_in_n = ~inh_req;
	// a bad store shows inverted junk, never good contents
	assign nv_ok = nv_valid;
	assign nv_relay = nv_valid ? NV_RELAY : ~NV_RELAY;
	assign nv_pon = nv_valid ? NV_PON : ~NV_PON;
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
// self-checking bench for the output controller
// assumes the design files and the plant model compile first
`timescale 1ns/1ps
`default_nettype none
`include "ocf_cfg.svh"
module testbench;
	import ocf_pkg::*;
	typedef struct packed {
		ocf_byte_t a;
		ocf_byte_t d;
		ocf_byte_t e;
	} ocf_row_t;
	localparam ocf_row_t rows [19] = '{
		'{`OCF_A_COUPLE, 8'h00, 8'h00}, '{`OCF_A_RELAY, 8'h04, 8'h04},
		'{`OCF_A_RELAY, 8'h0E, 8'h0E}, '{`OCF_A_RELAY, 8'h0F, 8'h0F},
		'{`OCF_A_COMP, 8'h00, 8'h00}, '{`OCF_A_COMP, 8'h01, 8'h01},
		'{`OCF_A_COMP, 8'h02, 8'h02}, '{`OCF_A_COMP, 8'h03, 8'h03},
		'{`OCF_A_COMP, 8'h10, 8'h00}, '{`OCF_A_COMP, 8'h11, 8'h03},
		'{`OCF_A_DFI, 8'h03, 8'h03}, '{`OCF_A_DFI, 8'h00, 8'h00},
		'{`OCF_A_PON, 8'h01, 8'h01}, '{`OCF_A_PON, 8'h00, 8'h00},
		'{`OCF_A_PROT, 8'h03, 8'h02}, '{`OCF_A_PROT, 8'h00, 8'h00},
		'{8'h20, 8'hFF, 8'h00}, '{`OCF_A_STATUS, 8'hFF, 8'hF0},
		'{`OCF_A_COUPLE, 8'h01, 8'h01}};
	localparam ocf_byte_t sb [5] = '{8'hFF, 8'h08, 8'h80, 8'h20, 8'h40};
	localparam ocf_byte_t pr [4] = '{8'h00, 8'h00, 8'h02, 8'h08};
	logic clk = 1'b0;
	logic rst = 1'b1;
	ocf_byte_t addr = 8'h00;
	ocf_byte_t wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	ocf_byte_t status_byte = 8'h00;
	logic overload = 1'b0;
	logic [1:0] fault_req = 2'h0;
	logic inh_req = 1'b0;
	logic nv_valid = 1'b0;
	ocf_byte_t rdata;
	ocf_byte_t got;
	ocf_comp_t comp_mode;
	logic [1:0] cc_in, level_on, relay_closed, sense_check;
	logic [3:0] nv_relay;
	logic ov_in, ot_in, remote_inhibit_in_n, nv_ok, nv_pon;
	logic fault_indicator_out, recall_slot_zero, fault_latched, ques_oc;
	int failures = 0;
	int compares = 0;
	// clock generator
	always #5 clk = ~clk;
	ocf_ctrl u_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .status_byte(status_byte), .ov_in(ov_in), .ot_in(ot_in),
		.cc_in(cc_in), .remote_inhibit_in_n(remote_inhibit_in_n), .nv_ok(nv_ok),
		.nv_relay(nv_relay), .nv_pon(nv_pon), .level_on(level_on),
		.relay_closed(relay_closed), .sense_check(sense_check), .comp_mode(comp_mode),
		.fault_indicator_out(fault_indicator_out), .recall_slot_zero(recall_slot_zero),
		.fault_latched(fault_latched), .ques_oc(ques_oc));
	ocf_plant u_plant (.level_on(level_on), .overload(overload), .fault_req(fault_req),
		.inh_req(inh_req), .nv_valid(nv_valid), .cc_in(cc_in), .ov_in(ov_in),
		.ot_in(ot_in), .remote_inhibit_in_n(remote_inhibit_in_n), .nv_ok(nv_ok),
		.nv_relay(nv_relay), .nv_pon(nv_pon));
	function automatic ocf_byte_t obs();
		return {2'h0, level_on, relay_closed, sense_check};
	endfunction
	task automatic chk(input ocf_byte_t g, input ocf_byte_t e);
		compares++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// bus cycles, entered just after a rising edge
	task automatic bus_wr(input ocf_byte_t a, input ocf_byte_t d);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic bus_rd(input ocf_byte_t a);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 got = rdata;
		@(posedge clk);
	endtask
	// enable write, then the two distinct pin states that follow
	task automatic en_seq(input ocf_byte_t d, input ocf_byte_t x1, input ocf_byte_t x2);
		ocf_byte_t prev;
		ocf_byte_t seen [$];
		prev = obs();
		wr <= 1'b1;
		addr <= `OCF_A_ENABLE;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		repeat (5) begin
			#1 if (obs() !== prev) seen.push_back(obs());
			prev = obs();
			@(posedge clk);
		end
		chk(seen.size() == 2 ? seen[0] : 8'hEE, x1);
		chk(seen.size() == 2 ? seen[1] : 8'hEE, x2);
	endtask
	// reset, then pins and every setting except protection against its reset value
	task automatic reset_chk(input logic v, input ocf_byte_t rl, input ocf_byte_t pn);
		ocf_byte_t ra [6];
		ocf_byte_t re [6];
		ra = '{`OCF_A_ENABLE, `OCF_A_COUPLE, `OCF_A_RELAY, `OCF_A_COMP, `OCF_A_DFI, `OCF_A_PON};
		re = '{8'h00, 8'h01, rl, 8'h03, 8'h00, pn};
		rst <= 1'b1;
		nv_valid <= v;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk({fault_indicator_out, recall_slot_zero, comp_mode, level_on, sense_check},
			{1'b0, pn[0], 2'h3, 4'h0});
		@(posedge clk);
		for (int k = 0; k < 6; k++) begin
			bus_rd(ra[k]);
			chk(got, re[k]);
		end
	endtask
	task automatic wrap_up();
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// watchdog
	initial begin
		#300000;
		failures++;
		wrap_up();
	end
	// main sequence
	initial begin
		reset_chk(1'b0, 8'h0F, 8'h00);
		foreach (rows[i]) begin
			bus_wr(rows[i].a, rows[i].d);
			bus_rd(rows[i].a);
			chk(got, rows[i].e);
			if (rows[i].a == `OCF_A_COMP) begin
				chk({6'h00, comp_mode}, rows[i].e);
			end
		end
		// coupled, hot switching: level before relays, no sense check
		en_seq(8'h01, 8'h30, 8'h3C);
		en_seq(8'h00, 8'h30, 8'h00);
		// uncoupled: out1 dry, out2 hot
		bus_wr(`OCF_A_COUPLE, 8'h00);
		bus_wr(`OCF_A_RELAY, 8'h0C);
		en_seq(8'h05, 8'h20, 8'h28);
		en_seq(8'h01, 8'h2D, 8'h3C);
		en_seq(8'h00, 8'h2C, 8'h28);
		bus_rd(`OCF_A_ENABLE);
		chk(got, 8'h02);
		// mode for a running output waits until it is off
		bus_wr(`OCF_A_RELAY, 8'h02);
		bus_rd(`OCF_A_STATUS);
		chk(got, 8'hE0);
		en_seq(8'h04, 8'h20, 8'h00);
		bus_rd(`OCF_A_STATUS);
		chk(got, 8'h20);
		// each fault source trips the latch; clear works once it is gone
		bus_wr(`OCF_A_COUPLE, 8'h01);
		bus_wr(`OCF_A_ENABLE, 8'h01);
		for (int i = 0; i < 4; i++) begin
			bus_wr(`OCF_A_PROT, pr[i]);
			fault_req <= (i < 2) ? 2'(1 << i) : 2'h0;
			overload <= (i == 2);
			inh_req <= (i == 3);
			repeat (8) @(posedge clk);
			#1 chk({fault_latched, ques_oc, 4'h0, level_on}, {1'b1, i == 2, 6'h00});
			@(posedge clk);
			bus_wr(`OCF_A_PROT, pr[i] | 8'h01);
			#1 if (i != 2) chk({7'h00, fault_latched}, 8'h01);
			@(posedge clk);
			fault_req <= 2'h0;
			overload <= 1'b0;
			inh_req <= 1'b0;
			repeat (4) @(posedge clk);
			bus_wr(`OCF_A_PROT, pr[i] | 8'h01);
			repeat (6) @(posedge clk);
			#1 chk({fault_latched, ques_oc, 4'h0, level_on}, 8'h03);
			@(posedge clk);
		end
		// live inhibit masks both outputs without latching
		bus_wr(`OCF_A_PROT, 8'h04);
		inh_req <= 1'b1;
		repeat (8) @(posedge clk);
		#1 chk({fault_latched, 5'h00, level_on}, 8'h00);
		@(posedge clk);
		inh_req <= 1'b0;
		repeat (8) @(posedge clk);
		#1 chk({fault_latched, 5'h00, level_on}, 8'h03);
		@(posedge clk);
		bus_wr(`OCF_A_PROT, 8'h00);
		// indicator follows only the chosen status bit
		for (int s = 0; s < 5; s++) begin
			bus_wr(`OCF_A_DFI, {4'h0, s[2:0], 1'b1});
			status_byte <= sb[s];
			repeat (3) @(posedge clk);
			#1 chk({7'h00, fault_indicator_out}, {7'h00, s != 0});
			@(posedge clk);
			status_byte <= ~sb[s];
			repeat (3) @(posedge clk);
			#1 chk({7'h00, fault_indicator_out}, 8'h00);
			@(posedge clk);
		end
		bus_wr(`OCF_A_DFI, 8'h02);
		status_byte <= 8'h08;
		repeat (3) @(posedge clk);
		#1 chk({7'h00, fault_indicator_out}, 8'h00);
		@(posedge clk);
		// mid-run reset with a good store
		reset_chk(1'b1, 8'h09, 8'h01);
		wrap_up();
	end
endmodule
`default_nettype wire
